// >>> core/ism_pkg.sv
// Purpose: Constants and carriers for the I2C slave message port
// Assumes: One 250 MHz clock; bus pins sampled synchronously
// Notes: Register window is read-only; writes carry messages or a one-byte pointer index
// What this block does
// - Slave only, fast-mode up to 400 kHz
// - Own address from upper seven config bits
// - 256 one-byte registers, top three defined
// - Reserved range reads return undefined filler
// - FD/FE report pending message byte count
// - Stream register pops byte or idle filler
// - Random read: index write then repeated start
// - Acknowledge own address byte low
// - Pointer increments per read, sticks at top
// - Pointer starts at stream register after reset
// - Registers read-only; message writes go to parser
// - Message writes two bytes or more; one sets pointer
// - Strap low routes pins to SPI instead
// - Full output queue drops new messages
// - Several protocols share one output stream
package ism_pkg;
  localparam logic [7:0] ADDR_CNT_HI = 8'hFD;
  localparam logic [7:0] ADDR_CNT_LO = 8'hFE;
  localparam logic [7:0] ADDR_STREAM = 8'hFF;
  localparam logic [7:0] IDLE_FILL = 8'hFF;
  localparam logic [7:0] RSVD_FILL = 8'hFF;
  localparam logic [7:0] PTR_RESET = 8'hFF;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h42;
  localparam int CLK_HZ = 250000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    ISM_IDLE = 3'b000,
    ISM_ADDR = 3'b001,
    ISM_ACK_ADDR = 3'b010,
    ISM_WR_BYTE = 3'b011,
    ISM_ACK_WR = 3'b100,
    ISM_RD_BYTE = 3'b101,
    ISM_ACK_RD = 3'b110
  } ism_state_t;
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } ism_msg_t;
endpackage : ism_pkg

// >>> core/ism_fifo.sv
// Purpose: Small valid/ready FIFO for outgoing message bytes
// Assumes: Single clock, asynchronous high reset
// Notes: Full and empty are exact; no overwrite when full
`timescale 1ns/1ps
module ism_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic in_valid, // Source has a word
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Sink takes word
  output logic [WIDTH-1:0] out_data, // Head word
  output logic [$clog2(DEPTH+1)-1:0] level // Words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  logic do_wr;
  logic do_rd;
  assign in_ready = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign level = cnt_reg;
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (do_wr ? 1'b1 : 1'b0) - (do_rd ? 1'b1 : 1'b0);
    end
  end
endmodule : ism_fifo

// >>> core/ism_port.sv
// Purpose: I2C slave message port with read-only register window
// Assumes: scl/sda inputs already synchronous to ref_clk
// Notes: Message source drops whole messages when queue cannot hold them
`timescale 1ns/1ps
module ism_port #(
  parameter int FIFO_DEPTH = 4,
  parameter logic [7:0] CFG_ADDR = {ism_pkg::DEV_ADDR_DEFAULT, 1'b0} // Arbitrary default
) (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic port_select, // Strap, low selects SPI
  input wire logic scl_in, // Bus clock level
  input wire logic sda_in, // Bus data level
  output logic sda_out, // Data drive value, always 0
  output logic sda_oe, // High while pulling data low
  input wire ism_pkg::ism_msg_t tx_msg, // Outgoing message byte
  input wire logic [7:0] tx_msg_len, // Bytes in message, on first
  output logic tx_drop, // Message was discarded
  output ism_pkg::ism_msg_t rx_msg, // Written byte to parser
  output logic spi_route // Pins routed to SPI
);
  ism_pkg::ism_state_t state_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wr_cnt_reg;
  logic [7:0] hold_reg;
  logic [7:0] rd_live;
  logic [7:0] rd_snap;
  logic byte_open_reg;
  logic [7:0] pend_hi_reg;
  logic [7:0] pend_lo_reg;
  logic [15:0] pending_reg;
  logic accept_msg_reg;
  logic sel_i2c;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic q_in_ready;
  logic q_out_valid;
  logic q_pop;
  logic q_push;
  logic [7:0] q_out_data;
  logic [$clog2(FIFO_DEPTH+1)-1:0] q_level;

  assign sel_i2c = port_select;
  assign scl_rise = sel_i2c && scl_in && !scl_d_reg;
  assign scl_fall = sel_i2c && !scl_in && scl_d_reg;
  assign start_seen = sel_i2c && scl_in && scl_d_reg && sda_d_reg && !sda_in;
  assign stop_seen = sel_i2c && scl_in && scl_d_reg && !sda_d_reg && sda_in;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] qd,
                                          input logic qv, input logic [7:0] hi,
                                          input logic [7:0] lo);
    if (a == ism_pkg::ADDR_STREAM) begin
      reg_read = qv ? qd : ism_pkg::IDLE_FILL;
    end else if (a == ism_pkg::ADDR_CNT_HI) begin
      reg_read = hi;
    end else if (a == ism_pkg::ADDR_CNT_LO) begin
      reg_read = lo;
    end else begin
      reg_read = ism_pkg::RSVD_FILL;
    end
  endfunction : reg_read

  // Live count for the first byte of a read, snapshot for the rest
  assign rd_live = reg_read(ptr_reg, q_out_data, q_out_valid,
                            pending_reg[15:8], pending_reg[7:0]);
  assign rd_snap = reg_read(ptr_reg, q_out_data, q_out_valid, pend_hi_reg, pend_lo_reg);

  // Messages are admitted whole or not at all, so the stream never holds a torn frame
  assign q_push = tx_msg.valid && (tx_msg.first ? (tx_msg_len != 8'h00 &&
                  {8'h00, tx_msg_len} <= 16'(FIFO_DEPTH) - 16'(q_level)) : accept_msg_reg);

  ism_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_queue (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(q_push),
    .in_ready(q_in_ready),
    .in_data(tx_msg.data),
    .out_valid(q_out_valid),
    .out_ready(q_pop),
    .out_data(q_out_data),
    .level(q_level)
  );

  // Any protocol may feed the one byte stream; source serialises them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      accept_msg_reg <= 1'b0;
      tx_drop <= 1'b0;
    end else begin
      tx_drop <= tx_msg.valid && tx_msg.first && !q_push;
      if (tx_msg.valid && tx_msg.first) begin
        accept_msg_reg <= q_push;
      end else if (tx_msg.valid && !q_in_ready) begin
        accept_msg_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      spi_route <= 1'b0;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
      spi_route <= !port_select;
    end
  end

  // Pending count follows the queue; both halves refresh on the same edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= 16'(q_level) - (q_pop ? 16'h0001 : 16'h0000);
    end
  end

  // Pop on the edge the stream byte is committed to the shift register
  assign q_pop = q_out_valid && scl_fall && (ptr_reg == ism_pkg::ADDR_STREAM) &&
                 ((state_reg == ism_pkg::ISM_ACK_ADDR && shift_reg[0]) ||
                  (state_reg == ism_pkg::ISM_ACK_RD && !sda_d_reg));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ism_pkg::ISM_IDLE;
      shift_reg <= '0;
      bit_reg <= '0;
      ptr_reg <= ism_pkg::PTR_RESET;
      wr_cnt_reg <= '0;
      hold_reg <= '0;
      byte_open_reg <= 1'b0;
      pend_hi_reg <= '0;
      pend_lo_reg <= '0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      rx_msg <= '0;
    end else begin
      rx_msg.valid <= 1'b0;
      if (!sel_i2c) begin
        // Pins belong to the SPI side; let go of the bus at once
        state_reg <= ism_pkg::ISM_IDLE;
        wr_cnt_reg <= '0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        // One data byte then stop sets the pointer only
        if (state_reg != ism_pkg::ISM_IDLE && wr_cnt_reg == 8'h01) begin
          ptr_reg <= hold_reg;
        end else if (wr_cnt_reg > 8'h01) begin
          rx_msg.valid <= 1'b1;
          rx_msg.first <= 1'b0;
          rx_msg.data <= hold_reg;
        end
        // Cleared so a later start cannot replay this write
        wr_cnt_reg <= '0;
        state_reg <= ism_pkg::ISM_IDLE;
        sda_oe <= 1'b0;
      end else if (start_seen) begin
        // Repeated start after one written byte: that byte is the read index
        if (wr_cnt_reg == 8'h01) begin
          ptr_reg <= hold_reg;
        end else if (wr_cnt_reg > 8'h01) begin
          rx_msg.valid <= 1'b1;
          rx_msg.first <= 1'b0;
          rx_msg.data <= hold_reg;
        end
        wr_cnt_reg <= '0;
        bit_reg <= '0;
        byte_open_reg <= 1'b0;
        sda_oe <= 1'b0;
        state_reg <= ism_pkg::ISM_ADDR;
      end else begin
        unique case (state_reg)
          ism_pkg::ISM_IDLE: begin
            sda_oe <= 1'b0;
          end
          ism_pkg::ISM_ADDR, ism_pkg::ISM_WR_BYTE: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_reg <= bit_reg + 3'h1;
              byte_open_reg <= 1'b1;
            end
            // The fall right after a start also finds the count at zero
            if (scl_fall && bit_reg == 3'h0 && byte_open_reg) begin
              byte_open_reg <= 1'b0;
              if (state_reg == ism_pkg::ISM_ADDR) begin
                if (shift_reg[7:1] == CFG_ADDR[7:1]) begin
                  sda_oe <= 1'b1;
                  state_reg <= ism_pkg::ISM_ACK_ADDR;
                end else begin
                  state_reg <= ism_pkg::ISM_IDLE;
                end
              end else begin
                // Earlier byte is now known not to be the last; forward it
                if (wr_cnt_reg != 8'h00) begin
                  rx_msg.valid <= 1'b1;
                  rx_msg.first <= (wr_cnt_reg == 8'h01);
                  rx_msg.data <= hold_reg;
                end
                hold_reg <= shift_reg;
                if (wr_cnt_reg != 8'hFF) begin
                  wr_cnt_reg <= wr_cnt_reg + 8'h01;
                end
                sda_oe <= 1'b1;
                state_reg <= ism_pkg::ISM_ACK_WR;
              end
            end
          end
          ism_pkg::ISM_ACK_ADDR, ism_pkg::ISM_ACK_WR: begin
            if (scl_fall) begin
              if (state_reg == ism_pkg::ISM_ACK_ADDR && shift_reg[0]) begin
                shift_reg <= rd_live;
                pend_hi_reg <= pending_reg[15:8];
                pend_lo_reg <= pending_reg[7:0];
                if (ptr_reg != ism_pkg::ADDR_STREAM) begin
                  ptr_reg <= ptr_reg + 8'h01;
                end
                sda_oe <= !rd_live[7];
                bit_reg <= '0;
                state_reg <= ism_pkg::ISM_RD_BYTE;
              end else begin
                sda_oe <= 1'b0;
                bit_reg <= '0;
                state_reg <= ism_pkg::ISM_WR_BYTE;
              end
            end
          end
          ism_pkg::ISM_RD_BYTE: begin
            if (scl_fall) begin
              if (bit_reg == ism_pkg::BIT_LAST) begin
                sda_oe <= 1'b0;
                state_reg <= ism_pkg::ISM_ACK_RD;
              end else begin
                sda_oe <= !shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 3'h1;
              end
            end
          end
          ism_pkg::ISM_ACK_RD: begin
            if (scl_fall) begin
              if (!sda_d_reg) begin
                // Count bytes come from the snapshot so FD/FE stay coherent
                shift_reg <= rd_snap;
                sda_oe <= !rd_snap[7];
                if (ptr_reg != ism_pkg::ADDR_STREAM) begin
                  ptr_reg <= ptr_reg + 8'h01;
                end
                bit_reg <= '0;
                state_reg <= ism_pkg::ISM_RD_BYTE;
              end else begin
                state_reg <= ism_pkg::ISM_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ism_pkg::ISM_IDLE;
          end
        endcase
      end
    end
  end
endmodule : ism_port

// >>> tb/ism_port_properties.sv
// Purpose: Concurrent checks on the message port pins
// Assumes: Single clock domain, rst async high
// Notes: Sees only the top module ports; bound from tb_top
`timescale 1ns/1ps
module ism_port_properties #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic port_select, // Strap
  input wire logic scl_in, // Bus clock level
  input wire logic sda_in, // Bus data level
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe, // Data pull enable
  input wire ism_pkg::ism_msg_t tx_msg, // Outgoing byte
  input wire logic [7:0] tx_msg_len, // Message length
  input wire logic tx_drop, // Drop pulse
  input wire ism_pkg::ism_msg_t rx_msg, // Written byte
  input wire logic spi_route // Pins to SPI
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence first_beat;
    tx_msg.valid && tx_msg.first;
  endsequence
  sequence strap_low;
    !port_select [*2];
  endsequence
  spi_follow_a: assert property (!$past(rst) |-> spi_route == !$past(port_select))
    else $error("spi route does not follow strap");
  strap_quiet_a: assert property (strap_low |=> !sda_oe)
    else $error("data pulled while strap selects spi");
  rx_spi_a: assert property (spi_route |-> !rx_msg.valid)
    else $error("written byte forwarded in spi mode");
  pull_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while bus clock high");
  oe_release_a: assert property ($rose(sda_oe) |-> ##[1:600] !sda_oe)
    else $error("data line held too long");
  oversize_drop_a: assert property (first_beat ##0 (tx_msg_len > FIFO_DEPTH) |=> tx_drop)
    else $error("oversized message not dropped");
  drop_cause_a: assert property (tx_drop |-> $past(tx_msg.valid && tx_msg.first))
    else $error("drop without a first byte");
  rx_pulse_a: assert property (rx_msg.valid |=> !rx_msg.valid)
    else $error("written byte pulse too long");
endmodule : ism_port_properties

// >>> tb/ism_host_model.sv
// Purpose: Bus master model driving the message port
// Assumes: Pull-up on data, so a released line reads high
// Notes: Serial clock stands high outside frames
`timescale 1ns/1ps
module ism_host_model #(
  parameter int HALF = 20
) (
  input wire logic ref_clk, // Core clock
  output logic scl, // Bus clock
  output logic sda_pull, // High while host pulls data low
  input wire logic sda_line // Resolved data level
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic gap();
    repeat (HALF) @(negedge ref_clk);
  endtask : gap
  // Data moves only while clock low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    @(negedge ref_clk);
    sda_pull = !b;
    gap();
    scl = 1'b1;
    gap();
    r = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda_pull = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_pull = 1'b1;
    gap();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    @(negedge ref_clk);
    sda_pull = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_pull = 1'b0;
    gap();
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // Nack on the last byte; indexes below the count pair are never sent
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rd_byte
endmodule : ism_host_model

// >>> tb/tb_top.sv
// Purpose: Scenario bench for the message port
// Assumes: Host model owns the bus; bench feeds the message source
// Notes: Expected bytes come from the queue contents pushed here and the bytes the host writes
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] WR_ADDR = {ism_pkg::DEV_ADDR_DEFAULT, 1'b0};
  localparam logic [7:0] RD_ADDR = {ism_pkg::DEV_ADDR_DEFAULT, 1'b1};
  logic ref_clk, rst, port_select, sda_out, sda_oe, tx_drop, spi_route, scl, host_pull;
  logic [7:0] tx_msg_len;
  ism_pkg::ism_msg_t tx_msg, rx_msg;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] drops = 8'h00;
  logic [7:0] first_cnt = 8'h00;
  logic [7:0] rx_q[$];
  wire logic sda_line = !(sda_oe || host_pull);
  ism_port #(.FIFO_DEPTH(4)) i_ism_port (.ref_clk(ref_clk), .rst(rst),
    .port_select(port_select), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .tx_msg(tx_msg), .tx_msg_len(tx_msg_len), .tx_drop(tx_drop),
    .rx_msg(rx_msg), .spi_route(spi_route));
  ism_host_model #(.HALF(20)) i_host (.ref_clk(ref_clk), .scl(scl), .sda_pull(host_pull),
    .sda_line(sda_line));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (tx_drop === 1'b1) drops <= drops + 8'h01;
    if (rx_msg.valid === 1'b1) rx_q.push_back(rx_msg.data);
    if (rx_msg.valid === 1'b1 && rx_msg.first === 1'b1) first_cnt <= first_cnt + 8'h01;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic push(input logic [7:0] len, input logic [7:0] base);
    for (int i = 0; i < len; i++) begin
      tx_msg = '{1'b1, i == 0, base + 8'(i)};
      tx_msg_len = len;
      @(negedge ref_clk);
    end
    tx_msg = '0;
    repeat (3) @(negedge ref_clk);
  endtask : push
  task automatic addr(input logic [7:0] a, input logic exp);
    logic ack;
    i_host.start();
    i_host.wr_byte(a, ack);
    check({7'h00, ack}, {7'h00, exp});
  endtask : addr
  task automatic rd(input logic use_idx, input logic [7:0] idx, input logic [7:0] exp[$]);
    logic ack;
    logic [7:0] d;
    if (use_idx) begin
      addr(WR_ADDR, 1'b1);
      i_host.wr_byte(idx, ack);
      check({7'h00, ack}, 8'h01);
    end
    addr(RD_ADDR, 1'b1);
    foreach (exp[i]) begin
      i_host.rd_byte(i == exp.size() - 1, d);
      check(d, exp[i]);
    end
    i_host.stop();
  endtask : rd
  task automatic sc_stream();
    push(8'h03, 8'hA0);
    check(drops, 8'h00);
    rd(1'b1, ism_pkg::ADDR_CNT_HI, '{8'h00, 8'h03, 8'hA0});
    rd(1'b0, 8'h00, '{8'hA1, 8'hA2, 8'hFF});
  endtask : sc_stream
  task automatic sc_drop();
    push(8'h05, 8'hB0);
    push(8'h02, 8'hC0);
    push(8'h02, 8'hE0);
    push(8'h01, 8'hD0);
    check(drops, 8'h02);
    rd(1'b0, 8'h00, '{8'hC0, 8'hC1, 8'hE0, 8'hE1, 8'hFF});
  endtask : sc_drop
  task automatic sc_strap();
    port_select = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({7'h00, spi_route}, 8'h01);
    check({7'h00, sda_out}, 8'h00);
    addr(WR_ADDR, 1'b0);
    i_host.stop();
    port_select = 1'b1;
    repeat (3) @(negedge ref_clk);
    check({7'h00, spi_route}, 8'h00);
    addr({7'h43, 1'b0}, 1'b0);
    i_host.stop();
  endtask : sc_strap
  task automatic sc_write();
    logic ack;
    addr(WR_ADDR, 1'b1);
    i_host.wr_byte(8'h5A, ack);
    i_host.wr_byte(8'hC3, ack);
    i_host.stop();
    repeat (4) @(negedge ref_clk);
    check(8'(rx_q.size()), 8'h02);
    check(rx_q[0], 8'h5A);
    check(rx_q[1], 8'hC3);
    check(first_cnt, 8'h01);
    addr(WR_ADDR, 1'b1);
    i_host.wr_byte(ism_pkg::ADDR_CNT_HI, ack);
    i_host.stop();
    rd(1'b0, 8'h00, '{8'h00, 8'h00, 8'hFF});
    check(8'(rx_q.size()), 8'h02);
  endtask : sc_write
  initial begin
    rst = 1'b1;
    port_select = 1'b1;
    tx_msg = '0;
    tx_msg_len = 8'h00;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rd(1'b0, 8'h00, '{8'hFF, 8'hFF});
    sc_stream();
    sc_drop();
    sc_strap();
    sc_write();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    $display("MISMATCH %0t run did not finish", $time);
    final_report();
  end
endmodule : tb_top
bind ism_port ism_port_properties #(.FIFO_DEPTH(FIFO_DEPTH)) i_ism_port_properties (
  .ref_clk, .rst, .port_select, .scl_in, .sda_in, .sda_out, .sda_oe, .tx_msg,
  .tx_msg_len, .tx_drop, .rx_msg, .spi_route);
